//--- common/aes_cfg.svh
// offsets, fields, reset values and timing counts of the encoder serial slave
`ifndef AES_CFG_SVH
`define AES_CFG_SVH

`define AES_CLK_HZ        40000000
`define AES_POS_W         20
`define AES_FRAME_W       31

`define AES_OFS_CTRL      5'h00
`define AES_OFS_STATUS    5'h04
`define AES_OFS_POS       5'h08
`define AES_OFS_IRQ_STAT  5'h0c
`define AES_OFS_IRQ_MASK  5'h10
`define AES_OFS_SETUP     5'h14

`define AES_CTRL_BISS     0
`define AES_CTRL_FIT      1
`define AES_CTRL_FAST     2
`define AES_CTRL_SETUP    3
`define AES_CTRL_RES_LSB  8
`define AES_CTRL_RES_MSB  12
`define AES_CTRL_RST      32'h00001400

`define AES_RES_MIN       5'h0c
`define AES_RES_MAX       5'h14
`define AES_RES_BISS_MIN  5'h11

`define AES_IRQ_DONE      0
`define AES_IRQ_FAULT     1
`define AES_IRQ_EARLY     2
`define AES_IRQ_W         3

`define AES_HOLD_NS       25000
`define AES_HOLD_CYC      ((`AES_HOLD_NS * (`AES_CLK_HZ / 1000000)) / 1000)
`define AES_RATE_HZ       35000
`define AES_FAST_HZ       375000
`define AES_RATE_CYC      (`AES_CLK_HZ / `AES_RATE_HZ)
`define AES_FAST_CYC      (`AES_CLK_HZ / `AES_FAST_HZ)
`define AES_CRC_POLY      6'h03

`endif

//--- common/aes_pkg.sv
// types of the encoder serial slave
package aes_pkg;
   typedef enum logic [1:0] {
      AES_IDLE  = 2'b00,
      AES_SHIFT = 2'b01,
      AES_HOLD  = 2'b10
   } aes_state_t;
endpackage

//--- common/aes_crc_if.sv
// carrier between the frame engine and the crc calculator
`timescale 1ns/1ps
`default_nettype none
interface aes_crc_if;
   logic [21:0] data;
   logic [4:0]  len;
   logic [5:0]  crc;
   modport calc (input data, input len, output crc);
   modport user (output data, output len, input crc);
endinterface
`default_nettype wire

//--- rtl/aes_crc6.sv
// crc over the msb-aligned position, fault and warning bits
`timescale 1ns/1ps
`default_nettype none
`include "aes_cfg.svh"
module aes_crc6 (
   aes_crc_if.calc c
);
   logic [5:0] acc;
   logic       fb;

   always_comb begin
      acc = 6'h00;
      fb  = 1'b0;
      for (int i = 0; i < 22; i++) begin
         if (5'(i) < c.len) begin
            fb  = c.data[21 - i] ^ acc[5];
            acc = {acc[4:0], 1'b0} ^ (fb ? `AES_CRC_POLY : 6'h00);
         end
      end
      c.crc = acc;
   end
endmodule // aes_crc6
`default_nettype wire

//--- rtl/aes_top.sv
// serial position output of the absolute encoder, ssi and biss-c framing
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "aes_cfg.svh"
module aes_top (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [4:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   input  wire logic                   master_clk,
   output logic                        data_out,
   input  wire logic [`AES_POS_W-1:0]  position_word,
   input  wire logic                   fault_in,
   output logic                        irq
);
   // register file
   logic [31:0]             ctrl_r;
   logic [`AES_IRQ_W-1:0]   irq_stat_r;
   logic [`AES_IRQ_W-1:0]   irq_stat_nxt;
   logic [`AES_IRQ_W-1:0]   irq_mask_r;
   logic                    setup_tx_r;
   logic                    wait_r;
   logic [31:0]             rdata_r;
   logic                    irq_r;

   // link side
   logic [2:0]              mclk_s_r;
   logic                    mclk_lvl_r;
   logic                    data_r;
   aes_pkg::aes_state_t     state_r;
   logic [`AES_FRAME_W-1:0] frame_r;
   logic [5:0]              cnt_r;
   logic [10:0]             hold_r;
   logic [10:0]             rate_r;
   logic [`AES_POS_W-1:0]   pos_smp_r;
   logic                    fault_d_r;

   aes_crc_if crc_c ();

   aes_crc6 u_crc (
      .c (crc_c)
   );

   // bus decode
   wire        req_w      = (avs_read | avs_write) & wait_r;
   wire        wr_w       = avs_write & ~wait_r;
   wire        sel_ctrl   = (avs_address == `AES_OFS_CTRL);
   wire        sel_stat   = (avs_address == `AES_OFS_STATUS);
   wire        sel_pos    = (avs_address == `AES_OFS_POS);
   wire        sel_ist    = (avs_address == `AES_OFS_IRQ_STAT);
   wire        sel_imk    = (avs_address == `AES_OFS_IRQ_MASK);
   wire        sel_setup  = (avs_address == `AES_OFS_SETUP);
   wire [4:0]  wr_res     = avs_writedata[`AES_CTRL_RES_MSB:`AES_CTRL_RES_LSB];
   wire        wr_biss    = avs_writedata[`AES_CTRL_BISS];
   wire [4:0]  res_min_w  = wr_biss ? `AES_RES_BISS_MIN : `AES_RES_MIN;
   wire        res_ok     = (wr_res >= res_min_w) && (wr_res <= `AES_RES_MAX);
   wire        ctrl_wr    = wr_w & sel_ctrl & res_ok & (state_r == aes_pkg::AES_IDLE);

   // control fields
   wire        biss_w     = ctrl_r[`AES_CTRL_BISS];
   wire        fit_w      = ctrl_r[`AES_CTRL_FIT];
   wire        fast_w     = ctrl_r[`AES_CTRL_FAST];
   wire        setup_w    = ctrl_r[`AES_CTRL_SETUP];
   wire [4:0]  res_w      = ctrl_r[`AES_CTRL_RES_MSB:`AES_CTRL_RES_LSB];

   // link clock edges, counted once the two last stages agree
   wire        mclk_stab  = (mclk_s_r[1] == mclk_s_r[2]);
   wire        mclk_rise  = mclk_stab & mclk_s_r[2] & ~mclk_lvl_r;
   wire        mclk_fall  = mclk_stab & ~mclk_s_r[2] & mclk_lvl_r;

   // frame assembly
   wire [4:0]  pad_w      = 5'(`AES_RES_MAX - res_w);
   wire [`AES_POS_W-1:0] pos_al_w = `AES_POS_W'(pos_smp_r << pad_w);
   wire        ssi_flt_w  = fault_in;
   wire        biss_err_w = fit_w ? ~fault_in : 1'b1;
   wire        warn_w     = 1'b1;
   wire [7:0]  tail_w     = {biss_err_w, warn_w, ~crc_c.crc};
   wire [`AES_FRAME_W-1:0] tail_sh_w = `AES_FRAME_W'({3'h0, tail_w, 20'h00000} >> res_w);
   wire [`AES_FRAME_W-1:0] biss_fr_w = {3'b010, pos_al_w, 8'h00} | tail_sh_w;
   wire [`AES_FRAME_W-1:0] ssi_fr_w  = {pos_al_w, 11'h000} |
                                       (`AES_FRAME_W'(ssi_flt_w & fit_w) << (6'd10 + 6'(pad_w)));
   wire [5:0]  biss_len_w = 6'(res_w) + 6'd11;
   wire [5:0]  ssi_len_w  = 6'(res_w) + (fit_w ? 6'd1 : 6'd0);
   wire [`AES_FRAME_W-1:0] frame_w = biss_w ? biss_fr_w : ssi_fr_w;
   wire [5:0]  len_w      = biss_w ? biss_len_w : ssi_len_w;

   // error and warning sit right below the last position bit
   assign crc_c.data = {pos_al_w, 2'b00} | (22'({biss_err_w, warn_w}) << pad_w);
   assign crc_c.len  = res_w + 5'd2;

   // engine control
   wire        idle_w     = (state_r == aes_pkg::AES_IDLE);
   wire        shift_w    = (state_r == aes_pkg::AES_SHIFT);
   wire        hold_w     = (state_r == aes_pkg::AES_HOLD);
   wire        start_w    = idle_w & mclk_fall & ~setup_w;
   wire        last_w     = shift_w & mclk_rise & (cnt_r == 6'd0);
   wire        early_w    = hold_w & mclk_fall;
   wire        hold_end_w = hold_w & (hold_r == 11'd0) & ~mclk_fall;
   // frame cut by the master: give up after one hold time without a rise
   wire        cut_w      = shift_w & (hold_r == 11'd0) & ~mclk_rise;
   wire        rate_tick  = (rate_r == 11'd0);
   wire [10:0] rate_ld_w  = fast_w ? 11'(`AES_FAST_CYC - 1) : 11'(`AES_RATE_CYC - 1);
   wire [10:0] hold_ld_w  = 11'(`AES_HOLD_CYC - 1);

   // interrupt events, set wins over clear
   wire [`AES_IRQ_W-1:0] ev_w     = {early_w, fault_in & ~fault_d_r, last_w};
   wire [`AES_IRQ_W-1:0] w1c_w    = (wr_w & sel_ist) ? avs_writedata[`AES_IRQ_W-1:0] : '0;
   assign irq_stat_nxt = (irq_stat_r & ~w1c_w) | ev_w;

   // read mux
   wire [31:0] stat_w     = {28'h0, mclk_lvl_r, state_r, ~idle_w};
   wire [31:0] rd_mux_w   = sel_ctrl  ? ctrl_r :
                            sel_stat  ? stat_w :
                            sel_pos   ? {12'h000, pos_smp_r} :
                            sel_ist   ? {29'h0, irq_stat_r} :
                            sel_imk   ? {29'h0, irq_mask_r} :
                            sel_setup ? {31'h0, setup_tx_r} : 32'h0;

   // bus slave: one wait cycle, then answer
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0;
      end else begin
         wait_r  <= ~req_w;
         rdata_r <= (req_w & avs_read) ? rd_mux_w : rdata_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= `AES_CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_r <= {19'h0, wr_res, 4'h0, avs_writedata[3:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask_r <= '0;
         setup_tx_r <= 1'b1;
      end else begin
         irq_mask_r <= (wr_w & sel_imk) ? avs_writedata[`AES_IRQ_W-1:0] : irq_mask_r;
         setup_tx_r <= (wr_w & sel_setup) ? avs_writedata[0] : setup_tx_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat_r <= '0;
         irq_r      <= 1'b0;
         fault_d_r  <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq_r      <= |(irq_stat_nxt & irq_mask_r);
         fault_d_r  <= fault_in;
      end
   end

   // master clock synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         mclk_s_r   <= 3'h7;
         mclk_lvl_r <= 1'b1;
      end else begin
         mclk_s_r   <= {mclk_s_r[1:0], master_clk};
         mclk_lvl_r <= mclk_stab ? mclk_s_r[2] : mclk_lvl_r;
      end
   end

   // position refresh timer
   always_ff @(posedge clk) begin
      if (rst) begin
         rate_r    <= 11'h000;
         pos_smp_r <= '0;
      end else begin
         rate_r    <= rate_tick ? rate_ld_w : rate_r - 11'd1;
         pos_smp_r <= rate_tick ? position_word : pos_smp_r;
      end
   end

   // frame engine
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= aes_pkg::AES_IDLE;
         frame_r <= '0;
         cnt_r   <= 6'h00;
         hold_r  <= 11'h000;
      end else begin
         case (state_r)
            aes_pkg::AES_IDLE: begin
               if (start_w) begin
                  state_r <= aes_pkg::AES_SHIFT;
                  frame_r <= frame_w;
                  cnt_r   <= len_w;
                  hold_r  <= hold_ld_w;
               end
            end
            aes_pkg::AES_SHIFT: begin
               if (last_w) begin
                  state_r <= aes_pkg::AES_HOLD;
                  hold_r  <= hold_ld_w;
               end else if (mclk_rise) begin
                  frame_r <= {frame_r[`AES_FRAME_W-2:0], 1'b0};
                  cnt_r   <= cnt_r - 6'd1;
                  hold_r  <= hold_ld_w;
               end else if (cut_w) begin
                  state_r <= aes_pkg::AES_IDLE;
               end else begin
                  hold_r <= hold_r - 11'd1;
               end
            end
            aes_pkg::AES_HOLD: begin
               if (early_w) begin
                  hold_r <= hold_ld_w;
               end else if (hold_end_w) begin
                  state_r <= aes_pkg::AES_IDLE;
               end else begin
                  hold_r <= hold_r - 11'd1;
               end
            end
            default: begin
               state_r <= aes_pkg::AES_IDLE;
            end
         endcase
      end
   end

   // data line driver
   always_ff @(posedge clk) begin
      if (rst) begin
         data_r <= 1'b1;
      end else if (setup_w) begin
         data_r <= setup_tx_r;
      end else if (shift_w & mclk_rise) begin
         data_r <= (cnt_r == 6'd0) ? 1'b0 : frame_r[`AES_FRAME_W-1];
      end else if (hold_end_w | idle_w) begin
         data_r <= 1'b1;
      end
   end

   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;
   assign data_out        = data_r;
   assign irq             = irq_r;
endmodule // aes_top
`default_nettype wire

//--- verification/aes_assertions.sv
// port checker of the encoder serial slave
`timescale 1ns/1ps
`default_nettype none
module aes_assertions (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        master_clk,
   input wire logic        data_out,
   input wire logic        irq
);
   logic [10:0] gap_r;
   logic [10:0] gap_nxt;
   logic        mclk_r;
   // cycles since the last master clock fall
   assign gap_nxt = (mclk_r && !master_clk) ? 11'h000 : gap_r + {10'h000, gap_r != 11'h7ff};
   always_ff @(posedge clk) begin
      mclk_r <= master_clk;
      gap_r  <= rst ? 11'h7ff : gap_nxt;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_answer_latency: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   a_no_idle_answer: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without request");
   a_reset_state: assert property (disable iff (1'b0) rst |=> avs_waitrequest && data_out && !irq)
      else $error("reset state wrong");
   a_rdata_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
      else $error("read data changed outside answer");
   a_fall_quiet: assert property ($fell(master_clk) |=> $stable(data_out) [*3])
      else $error("data changed after clock fall");
   a_hold_then_idle: assert property ($rose(data_out) |-> gap_r < 11'h008 || gap_r >= 11'h3e0)
      else $error("data released before hold end");
   a_irq_clear_cause: assert property ($fell(irq) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
      else $error("irq dropped without write");
endmodule // aes_assertions
bind aes_top aes_assertions u_chk (.clk, .rst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
   .master_clk, .data_out, .irq);
`default_nettype wire

//--- verification/aes_link_master.sv
// serial link master model, one master on the pair
`timescale 1ns/1ps
`default_nettype none
module aes_link_master (
   output logic      mclk,
   input wire logic  sdata
);
   initial mclk = 1'b1;
   // frame at 5 MHz, bit taken just before the next rise
   task automatic frame(input int n, output logic [31:0] bits);
      bits = 32'h0;
      #7 mclk = 1'b0;
      #100;
      for (int i = 0; i < n; i++) begin
         mclk = 1'b1;
         #100;
         if (i < n - 1) mclk = 1'b0;
         #95;
         bits = {bits[30:0], sdata};
         #5;
      end
   endtask
   task automatic pulse;
      #7 mclk = 1'b0;
      #100 mclk = 1'b1;
   endtask
   task automatic level(input logic v);
      #7 mclk = v;
   endtask
endmodule // aes_link_master
`default_nettype wire

//--- verification/aes_top_bench.sv
// self-checking bench of the encoder serial slave
`timescale 1ns/1ps
`default_nettype none
`include "aes_cfg.svh"
module aes_top_bench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   wire logic   master_clk;
   logic        data_out;
   logic [19:0] position_word = 20'h0;
   logic        fault_in = 1'b0;
   logic        irq;
   logic [31:0] q;
   int          failures = 0;
   int          check_count = 0;
   aes_top dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .master_clk, .data_out, .position_word, .fault_in, .irq);
   aes_link_master m (.mclk(master_clk), .sdata(data_out));
   initial forever #12.5 clk = ~clk;
   task automatic test_done;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      chk("bus latency", 32'd2, n);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] k, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q & k);
   endtask
   task automatic irqc(input string nm, input logic e);
      repeat (3) @(posedge clk);
      chk(nm, {31'h0, e}, {31'h0, irq});
   endtask
   function automatic logic [31:0] fexp(input logic bs, input int r, input logic ft, input logic fl,
                                        input logic [19:0] p);
      logic [31:0] f;
      logic [5:0]  c;
      logic        b;
      f = bs ? 32'h2 : 32'h0;
      c = 6'h00;
      for (int k = 0; k < (bs ? r + 2 : r); k++) begin
         b = (k < r) ? p[r - 1 - k] : ((k == r) ? (!ft || !fl) : 1'b1);
         f = {f[30:0], b};
         c = {c[4:0], 1'b0} ^ {4'h0, c[5] ^ b, c[5] ^ b};
      end
      if (bs) f = {f[25:0], ~c};
      else if (ft) f = {f[30:0], fl};
      return {f[30:0], 1'b0};
   endfunction
   task automatic link(input string nm, input logic bs, input int r, input logic ft, input logic fl,
                       input logic fs, input logic [19:0] p);
      logic [31:0] got;
      repeat (1100) @(posedge clk);
      bus(1'b1, `AES_OFS_CTRL, {19'h0, r[4:0], 5'h0, fs, ft, bs});
      repeat (1200) @(posedge clk);
      position_word <= p;
      fault_in <= fl;
      repeat (fs ? 150 : 1200) @(posedge clk);
      m.frame(bs ? r + 12 : r + ft + 1, got);
      chk(nm, fexp(bs, r, ft, fl, p), got);
      rdc("hold status", `AES_OFS_STATUS, 32'h7, 32'h5);
      rdc("pos sample", `AES_OFS_POS, 32'h000fffff, {12'h000, p});
   endtask
   task automatic t_reset;
      rdc("ctrl reset", `AES_OFS_CTRL, 32'hffffffff, `AES_CTRL_RST);
      rdc("status reset", `AES_OFS_STATUS, 32'h7, 32'h0);
      rdc("setup reset", `AES_OFS_SETUP, 32'h1, 32'h1);
      rdc("irq reset", `AES_OFS_IRQ_STAT, 32'h7, 32'h0);
      rdc("unmapped", 5'h1c, 32'hffffffff, 32'h0);
      chk("idle data", 32'h1, {31'h0, data_out});
   endtask
   task automatic t_early;
      bus(1'b1, `AES_OFS_IRQ_MASK, 32'h4);
      m.pulse();
      irqc("irq early", 1'b1);
      rdc("irq status", `AES_OFS_IRQ_STAT, 32'h7, 32'h7);
      bus(1'b1, `AES_OFS_IRQ_MASK, 32'h0);
      irqc("irq masked", 1'b0);
      bus(1'b1, `AES_OFS_IRQ_MASK, 32'h4);
      irqc("irq unmasked", 1'b1);
      bus(1'b1, `AES_OFS_IRQ_STAT, 32'h7);
      irqc("irq cleared", 1'b0);
      rdc("stat cleared", `AES_OFS_IRQ_STAT, 32'h7, 32'h0);
      bus(1'b1, `AES_OFS_CTRL, 32'h00001400);
      rdc("ctrl busy", `AES_OFS_CTRL, 32'hffffffff, 32'h00001405);
      repeat (1100) @(posedge clk);
      bus(1'b1, `AES_OFS_CTRL, 32'h00001001);
      rdc("ctrl bad res", `AES_OFS_CTRL, 32'hffffffff, 32'h00001405);
   endtask
   task automatic t_cut;
      m.pulse();
      rdc("cut busy", `AES_OFS_STATUS, 32'h7, 32'h3);
      repeat (1100) @(posedge clk);
      rdc("cut ends", `AES_OFS_STATUS, 32'h7, 32'h0);
      chk("cut data", 32'h1, {31'h0, data_out});
   endtask
   task automatic t_setup;
      bus(1'b1, `AES_OFS_CTRL, 32'h00001408);
      bus(1'b1, `AES_OFS_SETUP, 32'h0);
      repeat (3) @(posedge clk);
      chk("setup tx low", 32'h0, {31'h0, data_out});
      bus(1'b1, `AES_OFS_SETUP, 32'h1);
      repeat (3) @(posedge clk);
      chk("setup tx high", 32'h1, {31'h0, data_out});
      m.level(1'b0);
      repeat (8) @(posedge clk);
      rdc("setup rx low", `AES_OFS_STATUS, 32'h8, 32'h0);
      m.level(1'b1);
      repeat (8) @(posedge clk);
      rdc("setup rx high", `AES_OFS_STATUS, 32'h8, 32'h8);
      bus(1'b1, `AES_OFS_CTRL, 32'h00001400);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      link("ssi fit err", 1'b0, 12, 1'b1, 1'b1, 1'b0, 20'hf0abc);
      link("ssi plain", 1'b0, 12, 1'b0, 1'b1, 1'b0, 20'h3af0f);
      link("ssi 20 fast", 1'b0, 20, 1'b1, 1'b0, 1'b1, 20'hc3a5e);
      link("biss 17 err", 1'b1, 17, 1'b1, 1'b1, 1'b0, 20'h1d2b6);
      link("biss 20", 1'b1, 20, 1'b0, 1'b1, 1'b1, 20'h5b7c1);
      t_early();
      t_cut();
      t_setup();
      test_done();
   end
   initial begin
      #1500000;
      failures++;
      test_done();
   end
endmodule // aes_top_bench
`default_nettype wire
